/* core/flash_cfg_params.svh */
// constants for the flash configuration-space access block
`ifndef FLASH_CFG_PARAMS_SVH
`define FLASH_CFG_PARAMS_SVH
`define CFG_UID_FIRST   15'h0000
`define CFG_UID_LAST    15'h0003
`define CFG_DEVID_ADDR  15'h0006
`define CFG_WORD_FIRST  15'h0007
`define CFG_WORD_LAST   15'h0008
`define CFG_DEPTH       9
`define CFG_IDX_W       4
`define ADDR_HIGH_PAD   1'h1
`define DATA_HIGH_PAD   2'h0
`define READ_STALL      2'h2
`define DEVID_DEFAULT   14'h1234
`define WORD_RST        14'h0000
`define BYTE_RST        8'h00
`define ADDR_HIGH_RST   8'h80
`define FILL_WORD       14'h0000
`define DATA_HI_FIELD   13:8
`define ADDR_HI_FIELD   14:8
`define LOW_BYTE        7:0
`endif

/* core/flash_cfg_pkg.sv */
// types for the flash configuration-space access block
package flash_cfg_pkg;
  typedef enum logic [1:0] {st_idle, st_exec, st_fetch} rd_state_t;
endpackage : flash_cfg_pkg

/* core/cfg_word_mem.sv */
// small configuration-space word store with registered read
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg_params.svh"
module cfg_word_mem #(
  parameter int WIDTH = 14,
  parameter int DEPTH = `CFG_DEPTH,
  parameter int AW    = `CFG_IDX_W
) (
  input  wire logic             core_clk,
  input  wire logic [AW-1:0]    wr_idx,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule : cfg_word_mem
`default_nettype wire

/* core/flash_cfg_access.sv */
// configuration-space decode, read sequencing and permission checks
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg_params.svh"
// What this block does
// - select bit routes access to config region
// - user IDs rw, device ID ro, config words ro
// - reads outside map return all zeros
// - read executes next slot, ignores second
// - data high byte top bits read zero
// - address high byte top bit reads one
module flash_cfg_access
  import flash_cfg_pkg::*;
#(
  parameter logic [13:0] DEVID = `DEVID_DEFAULT // arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        config_space_select,
  input  wire logic [14:0] pm_addr,
  input  wire logic        rd_trigger,
  input  wire logic        wr_trigger,
  input  wire logic [13:0] wr_word,
  input  wire logic [13:0] pm_rd_word,
  output logic      [7:0]  nvm_data_low,
  output logic      [7:0]  nvm_data_high,
  output logic      [7:0]  nvm_addr_low,
  output logic      [7:0]  nvm_addr_high,
  output logic             core_stall,
  output logic             rd_busy,
  output logic             wr_refused,
  output logic             pm_wr_en
);
  rd_state_t   state;
  rd_state_t   next_state;
  logic [13:0] data;
  logic [13:0] next_data;
  logic        next_sel_lat;
  logic        next_stall;
  logic        next_busy;
  logic        next_refused;
  logic        next_pmwe;
  // next values of the output registers
  logic [7:0]  next_data_low;
  logic [7:0]  next_data_high;
  logic [7:0]  next_addr_low;
  logic [7:0]  next_addr_high;
  logic        sel_lat;
  logic        rd_ok;
  logic        is_uid;
  logic        is_devid;
  logic        cw_wr;
  logic [13:0] mem_q;
  logic [`CFG_IDX_W-1:0] idx;

  ////////////////////////////////////////////////////////////////
  // config region decode
  assign is_uid   = pm_addr >= `CFG_UID_FIRST && pm_addr <= `CFG_UID_LAST;
  assign is_devid = pm_addr == `CFG_DEVID_ADDR;
  assign rd_ok    = is_uid || is_devid || (pm_addr >= `CFG_WORD_FIRST && pm_addr <= `CFG_WORD_LAST);
  assign cw_wr    = wr_trigger && config_space_select && is_uid && state == st_idle;
  assign idx      = pm_addr[`CFG_IDX_W-1:0];
  // decode and store read use pm_addr live, so it must hold through a read;
  // out-of-map indexes may read junk but never reach the data word

  cfg_word_mem u_mem (
    .core_clk (core_clk),
    .wr_idx   (idx),
    .wr_en    (cw_wr),
    .wr_data  (wr_word),
    .rd_idx   (idx),
    .rd_data  (mem_q)
  );

  ////////////////////////////////////////////////////////////////
  // read sequencer: trigger, executed slot, ignored slot
  always_comb begin
    next_state   = state;
    next_data    = data;
    next_sel_lat = sel_lat;
    case (state)
      st_idle: begin
        if (rd_trigger) begin
          next_state   = st_exec;
          next_sel_lat = config_space_select;
        end
      end
      // next instruction runs, then one stalled slot
      st_exec: begin
        next_state = st_fetch;
      end
      st_fetch: begin
        next_state = st_idle;
        if (!sel_lat) begin
          next_data = pm_rd_word;
        end else if (!rd_ok) begin
          next_data = `FILL_WORD;
        end else if (is_devid) begin
          // device id is a read-only constant
          next_data = DEVID;
        end else begin
          next_data = mem_q;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state   <= st_idle;
      data    <= `WORD_RST;
      sel_lat <= 1'b0;
    end else begin
      state   <= next_state;
      data    <= next_data;
      sel_lat <= next_sel_lat;
    end
  end

  ////////////////////////////////////////////////////////////////
  // write responses: one-cycle pulses, so no sticky flag to clear
  always_comb begin
    // non user-id config writes flagged, never stored
    next_refused = wr_trigger && config_space_select && !is_uid;
    // select low passes the write to main memory while the sequencer is idle
    next_pmwe    = wr_trigger && !config_space_select && state == st_idle;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_refused <= 1'b0;
      pm_wr_en   <= 1'b0;
    end else begin
      wr_refused <= next_refused;
      pm_wr_en   <= next_pmwe;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs registered from next values so the core never sees decode
  // glitches; the price is a second copy of the data word
  always_comb begin
    // stall covers the ignored second slot
    next_stall     = next_state == st_fetch;
    next_busy      = next_state != st_idle;
    next_data_high = {`DATA_HIGH_PAD, next_data[`DATA_HI_FIELD]};
    next_data_low  = next_data[`LOW_BYTE];
    next_addr_high = {`ADDR_HIGH_PAD, pm_addr[`ADDR_HI_FIELD]};
    next_addr_low  = pm_addr[`LOW_BYTE];
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      core_stall    <= 1'b0;
      rd_busy       <= 1'b0;
      nvm_data_high <= `BYTE_RST;
      nvm_data_low  <= `BYTE_RST;
      nvm_addr_high <= `ADDR_HIGH_RST;
      nvm_addr_low  <= `BYTE_RST;
    end else begin
      core_stall    <= next_stall;
      rd_busy       <= next_busy;
      nvm_data_high <= next_data_high;
      nvm_data_low  <= next_data_low;
      nvm_addr_high <= next_addr_high;
      nvm_addr_low  <= next_addr_low;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // checks sample the registered outputs one edge after their cause
  read_stall_a: assert property (rd_trigger && state == st_idle |=> !core_stall ##1 core_stall ##1 !core_stall)
    else $error("read stall slot misplaced");
  rd_busy_a: assert property (rd_trigger && state == st_idle |=> rd_busy ##1 rd_busy ##1 !rd_busy)
    else $error("read busy window wrong");
  zero_fill_a: assert property (state == st_fetch && sel_lat && !rd_ok |=> data == `FILL_WORD)
    else $error("outside read not zeroed");
  devid_read_a: assert property (state == st_fetch && sel_lat && is_devid |=> data == DEVID)
    else $error("device id not returned");
  uid_read_a: assert property (state == st_fetch && sel_lat && is_uid |=> data == $past(mem_q))
    else $error("user id read wrong");
  no_cw_write_a: assert property (wr_trigger && config_space_select && !is_uid |=> wr_refused && !pm_wr_en)
    else $error("refused write not flagged");
  cfg_no_pm_a: assert property (wr_trigger && config_space_select |=> !pm_wr_en)
    else $error("config write reached main memory");
  main_route_a: assert property (state == st_fetch && !sel_lat |=> data == $past(pm_rd_word))
    else $error("main memory read misrouted");
  // the pad is a constant, so this also checks the bytes mirror the word
  data_pad_a: assert property ({nvm_data_high, nvm_data_low} == {`DATA_HIGH_PAD, data})
    else $error("data high pad not zero");
  // first edge after reset still shows the reset copy, not the address
  addr_pad_a: assert property ($past(nrst) |->
    nvm_addr_high == {`ADDR_HIGH_PAD, $past(pm_addr[`ADDR_HI_FIELD])})
    else $error("address high byte wrong");
  // writes may come back to back, so only the pulse this write causes counts
  uid_write_a: assert property (cw_wr |=> !wr_refused)
    else $error("user id write refused");

  // main scenarios
  cfg_read_c: cover property (state == st_fetch && sel_lat && rd_ok);
  zero_read_c: cover property (state == st_fetch && sel_lat && !rd_ok);
  refused_c: cover property (wr_refused);
  pm_read_c: cover property (state == st_fetch && !sel_lat);
  uid_write_c: cover property (cw_wr);
endmodule : flash_cfg_access
`default_nettype wire

/* testbench/pm_model.sv */
// program memory model standing behind the access block
`timescale 1ns/100ps
`default_nettype none
module pm_model (
  input  wire logic        core_clk,
  input  wire logic [14:0] pm_addr,
  input  wire logic        pm_wr_en,
  input  wire logic [13:0] wr_word,
  output logic      [13:0] pm_rd_word
);
  logic [13:0] mem [16];
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 14'h0a50 ^ 14'(i);
    end
  end
  always @(posedge core_clk) begin
    if (pm_wr_en === 1'h1) begin
      mem[pm_addr[3:0]] <= wr_word;
    end
  end
  assign pm_rd_word = mem[pm_addr[3:0]];
endmodule : pm_model
`default_nettype wire

/* testbench/flash_cfg_access_tb.sv */
// self-checking bench for the configuration-space access block
`timescale 1ns/100ps
`default_nettype none
`include "flash_cfg_params.svh"
module flash_cfg_access_tb;
  logic        core_clk = 0, nrst = 0, sel = 0, rd_trigger = 0, wr_trigger = 0;
  logic [14:0] pm_addr  = '0;
  logic [13:0] wr_word  = '0;
  logic [13:0] pm_rd_word;
  logic [7:0]  nvm_data_low, nvm_data_high, nvm_addr_low, nvm_addr_high;
  logic        core_stall, rd_busy, wr_refused, pm_wr_en;
  int          n_mismatch = 0, n_checks = 0;
  always #2 core_clk = ~core_clk;
  flash_cfg_access u_dut (.core_clk(core_clk), .nrst(nrst), .config_space_select(sel), .pm_addr(pm_addr),
    .rd_trigger(rd_trigger), .wr_trigger(wr_trigger), .wr_word(wr_word), .pm_rd_word(pm_rd_word),
    .nvm_data_low(nvm_data_low), .nvm_data_high(nvm_data_high), .nvm_addr_low(nvm_addr_low),
    .nvm_addr_high(nvm_addr_high), .core_stall(core_stall), .rd_busy(rd_busy), .wr_refused(wr_refused),
    .pm_wr_en(pm_wr_en));
  pm_model u_pm (.core_clk(core_clk), .pm_addr(pm_addr), .pm_wr_en(pm_wr_en), .wr_word(wr_word),
    .pm_rd_word(pm_rd_word));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one write pulse, then a spare cycle so pm_model, written on the registered pm_wr_en, sees a steady address
  task automatic wr(input logic s, input logic [14:0] a, input logic [13:0] d);
    sel        = s;
    pm_addr    = a;
    wr_word    = d;
    wr_trigger = 1'h1;
    @(posedge core_clk);
    #1;
    wr_trigger = 1'h0;
    chk(wr_refused, s && a > 15'h0003);
    chk(pm_wr_en, !s);
    @(posedge core_clk);
    #1;
  endtask : wr
  task automatic rd(input logic s, input logic [14:0] a, input logic [13:0] e);
    int stalls;
    stalls     = 0;
    sel        = s;
    pm_addr    = a;
    rd_trigger = 1'h1;
    @(posedge core_clk);
    #1;
    rd_trigger = 1'h0;
    for (int i = 0; i < 8 && rd_busy !== 1'h0; i++) begin
      stalls += (core_stall === 1'h1);
      @(posedge core_clk);
      #1;
    end
    stalls += (core_stall === 1'h1);
    chk(rd_busy, 1'h0);
    chk(stalls, 1);
    chk({nvm_data_high, nvm_data_low}, {2'h0, e});
    chk({nvm_addr_high, nvm_addr_low}, {1'h1, a});
  endtask : rd
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    nrst = 1'h1;
    chk({nvm_addr_high, nvm_addr_low, nvm_data_high, nvm_data_low}, 32'h8000_0000);
    chk({core_stall, rd_busy, wr_refused, pm_wr_en}, 4'h0);
    for (int i = 0; i < 4; i++) wr(1'h1, 15'(i), 14'h2c81 + 14'(i));
    for (int i = 0; i < 4; i++) rd(1'h1, 15'(i), 14'h2c81 + 14'(i));
    $display("test user ids done");
    for (int i = 4; i < 10; i++) wr(1'h1, 15'(i), 14'h0555);
    wr(1'h1, 15'h7f02, 14'h0555);
    rd(1'h1, 15'h0006, `DEVID_DEFAULT);
    rd(1'h1, 15'h0004, 14'h0000);
    rd(1'h1, 15'h0005, 14'h0000);
    rd(1'h1, 15'h0009, 14'h0000);
    rd(1'h1, 15'h7fff, 14'h0000);
    rd(1'h1, 15'h0002, 14'h2c83);
    $display("test refused and unlisted done");
    rd(1'h0, 15'h0003, 14'h0a53);
    wr(1'h0, 15'h7f05, 14'h3fff);
    rd(1'h0, 15'h7f05, 14'h3fff);
    rd(1'h1, 15'h0003, 14'h2c84);
    $display("test main memory done");
    // read a word into an image, change one bit, write back, verify
    rd(1'h0, 15'h0004, 14'h0a54);
    wr(1'h0, 15'h0004, 14'h0b54);
    rd(1'h0, 15'h0004, 14'h0b54);
    $display("test modify and verify done");
    // core reset mid-run: outputs drop, user ids survive
    nrst = 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    nrst = 1'h1;
    chk({nvm_addr_high, nvm_addr_low, nvm_data_high, nvm_data_low}, 32'h8000_0000);
    rd(1'h1, 15'h0001, 14'h2c82);
    $display("test reset done");
    report_and_stop();
  end
  // generous bound: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : flash_cfg_access_tb
`default_nettype wire
